// ==== inc/mibuf_consts.svh ====
// Constants for the indirect sector buffer access port.
// Assumes inclusion by the package and the design files of this block.
`ifndef MIBUF_CONSTS_SVH
`define MIBUF_CONSTS_SVH

// Register offsets within the group
`define MIBUF_OFS_BYTE0 6'h20
`define MIBUF_OFS_BYTE1 6'h21
`define MIBUF_OFS_BYTE2 6'h22
`define MIBUF_OFS_BYTE3 6'h23
`define MIBUF_OFS_ADRL 6'h24
`define MIBUF_OFS_ADRH 6'h25

// Field positions in the address high byte
`define MIBUF_BIT_DIR 7
`define MIBUF_BIT_BUSY 6

// Widths and reset values
`define MIBUF_ADR_W 13
`define MIBUF_RST_BYTE 8'h00
`define MIBUF_RST_ADR 13'h0000

`endif

// ==== inc/mibuf_pkg.sv ====
// Types for the indirect sector buffer access port.
// Assumes the constants header sits alongside in inc/.
`include "mibuf_consts.svh"
package mibuf_pkg;

  // Port sequencer states
  typedef enum logic [1:0] {
    MIBUF_IDLE = 2'b00,
    MIBUF_WR = 2'b01,
    MIBUF_RD = 2'b10
  } mibuf_state_t;

  // Complete state of the port
  typedef struct packed {
    mibuf_state_t state;
    logic [7:0] byte0;
    logic [7:0] byte1;
    logic [7:0] byte2;
    logic [7:0] byte3;
    logic [`MIBUF_ADR_W-1:0] adr;
    logic dir;
    logic busy;
    logic [7:0] rdata;
    logic mem_req;
    logic mem_we;
    logic [`MIBUF_ADR_W-1:0] mem_adr;
    logic [31:0] mem_wdata;
  } mibuf_regs_t;

endpackage

// ==== tb/mcu_indirect_buffer_access_tb.sv ====
// Bench for the buffer access port.
// Assumes the bench plays firmware and buffer memory.
`timescale 1ns/1ps
`default_nettype none
module mcu_indirect_buffer_access_tb;
  logic i_clk, i_reset, i_reg_wr, i_reg_rd, i_mem_done, o_busy, o_mem_req, o_mem_we;
  logic [5:0] i_reg_addr;
  logic [7:0] i_reg_wdata, o_reg_rdata;
  logic [31:0] i_mem_rdata, o_mem_wdata;
  logic [12:0] o_mem_addr;
  bit [31:0] mem [8192];
  int errors, tests_run;
  mibuf_port u_mibuf_port (.*);
  initial begin
    i_clk = 0;
    forever #5 i_clk = ~i_clk;
  end
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wr(logic [5:0] a, logic [7:0] d);
    @(posedge i_clk);
    #1 i_reg_addr = a;
    i_reg_wdata = d;
    i_reg_wr = 1;
    @(posedge i_clk);
    #1 i_reg_wr = 0;
  endtask
  task automatic rd(logic [5:0] a, logic [7:0] e, string n);
    @(posedge i_clk);
    #1 i_reg_addr = a;
    i_reg_rd = 1;
    @(posedge i_clk);
    #1 i_reg_rd = 0;
    chk(n, 32'(e), 32'(o_reg_rdata));
  endtask
  // Bounded wait; a hang ends the run
  task automatic idle;
    for (int k = 0; k < 40; k++) begin
      @(posedge i_clk);
      #1;
      if (o_busy === 1'b0) return;
    end
    errors++;
    close_out();
  endtask
  // Buffer answers two cycles late; request looked at once it has settled
  always @(posedge i_clk) begin : resp
    logic [12:0] a;
    logic [31:0] d;
    logic w;
    #1;
    if (o_mem_req === 1'b1) begin
      a = o_mem_addr;
      d = o_mem_wdata;
      w = o_mem_we;
      repeat (2) @(posedge i_clk);
      #1 i_mem_rdata = mem[a];
      if (w) mem[a] = d;
      i_mem_done = 1;
      @(posedge i_clk);
      #1 i_mem_done = 0;
      i_mem_rdata = ~i_mem_rdata;
    end
  end
  initial begin
    {i_reset, i_reg_wr, i_reg_rd, i_reg_addr, i_reg_wdata, i_mem_done, i_mem_rdata} = '0;
    i_reset = 1;
    repeat (2) @(posedge i_clk);
    #1 i_reset = 0;
    for (int k = 0; k < 6; k++) rd(6'h20 + 6'(k), 8'h00, "reset");
    rd(6'h30, 8'h00, "unmapped");
    // Write burst across the top of the address space
    wr(6'h24, 8'hfe);
    wr(6'h25, 8'h1f);
    for (int w = 0; w < 2; w++) begin
      for (int k = 0; k < 4; k++) wr(6'h20 + 6'(k), 8'(16 * w + k));
      idle();
    end
    chk("word0", 32'h03020100, mem[13'h1ffe]);
    chk("word1", 32'h13121110, mem[13'h1fff]);
    rd(6'h24, 8'h00, "low");
    rd(6'h25, 8'h00, "high");
    $display("write burst done");
    // Read burst with a partial word
    wr(6'h24, 8'hfe);
    wr(6'h25, 8'h9f);
    idle();
    for (int k = 0; k < 4; k++) rd(6'h20 + 6'(k), 8'(k), "rbyte");
    idle();
    rd(6'h22, 8'h12, "part");
    rd(6'h24, 8'h00, "nofetch");
    rd(6'h25, 8'h80, "rhigh");
    rd(6'h23, 8'h13, "last");
    idle();
    rd(6'h24, 8'h01, "next");
    $display("read burst done");
    close_out();
  end
endmodule
bind mibuf_port mibuf_chk u_mibuf_chk (.*);
`default_nettype wire

// ==== tb/mibuf_chk.sv ====
// Checker for the buffer access port.
// Assumes a bind onto the port module.
`timescale 1ns/1ps
`default_nettype none
module mibuf_chk (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [5:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_wdata,
  input wire logic [7:0] o_reg_rdata,
  input wire logic o_busy,
  input wire logic o_mem_req,
  input wire logic o_mem_we,
  input wire logic [12:0] o_mem_addr,
  input wire logic i_mem_done
);
  logic dir_r;
  logic [12:0] last_r;
  // Direction shadow, since it has no port
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      dir_r <= 1'b0;
      last_r <= 13'h0000;
    end else begin
      if (i_reg_wr && i_reg_addr == 6'h25 && !o_busy) dir_r <= i_reg_wdata[7];
      if (o_mem_req) last_r <= o_mem_addr;
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  wire hi_rd = i_reg_rd && i_reg_addr == 6'h25;
  sequence rd_b3;
    i_reg_rd && i_reg_addr == 6'h23 && !o_busy && dir_r;
  endsequence
  wr_commit_a: assert property (i_reg_wr && i_reg_addr == 6'h23 && !o_busy && !dir_r
    |=> o_mem_req && o_mem_we && o_busy) else $error("no store");
  rd_fetch_a: assert property (i_reg_wr && i_reg_addr == 6'h25 && i_reg_wdata[7] && !o_busy
    |=> o_mem_req && !o_mem_we && o_busy && o_mem_addr[12:8] == $past(i_reg_wdata[4:0]))
    else $error("no fetch");
  done_clear_a: assert property (o_busy && i_mem_done |=> !o_busy) else $error("busy stuck");
  next_fetch_a: assert property (rd_b3 |=> o_mem_req && !o_mem_we
    && o_mem_addr == last_r + 13'h0001) else $error("bad prefetch");
  no_fetch_a: assert property (i_reg_rd && i_reg_addr < 6'h23 |=> !o_mem_req)
    else $error("stray fetch");
  busy_hold_a: assert property (o_busy && !i_mem_done |=> o_busy) else $error("busy drop");
  busy_bit_a: assert property (hi_rd |=> o_reg_rdata[6] == $past(o_busy))
    else $error("busy bit");
  dir_bit_a: assert property (hi_rd |=> o_reg_rdata[7] == dir_r) else $error("dir bit");
endmodule
`default_nettype wire

// ==== verilog/mibuf_byte_mux.sv ====
// Read-data selector for the four data bytes and the address registers.
// Assumes the register offset arrives already decoded to six bits.
`timescale 1ns/1ps
`default_nettype none
`include "mibuf_consts.svh"
module mibuf_byte_mux
  import mibuf_pkg::*;
(
  input wire logic [5:0] i_addr,
  input wire logic [31:0] i_word,
  input wire logic [`MIBUF_ADR_W-1:0] i_adr,
  input wire logic i_dir,
  input wire logic i_busy,
  output logic [7:0] o_data
);

  // ****************************************
  // Readback selection
  // ****************************************
  // Unmapped offsets read zero; bit 5 of high byte is reserved zero
  always_comb begin
    case (i_addr)
      `MIBUF_OFS_BYTE0: o_data = i_word[7:0];
      `MIBUF_OFS_BYTE1: o_data = i_word[15:8];
      `MIBUF_OFS_BYTE2: o_data = i_word[23:16];
      `MIBUF_OFS_BYTE3: o_data = i_word[31:24];
      `MIBUF_OFS_ADRL: o_data = i_adr[7:0];
      `MIBUF_OFS_ADRH: o_data = {i_dir, i_busy, 1'b0, i_adr[12:8]};
      default: o_data = 8'h00;
    endcase
  end

endmodule
`default_nettype wire

// ==== verilog/mibuf_port.sv ====
// Indirect firmware access port to the sector buffer memory.
// Assumes a same-clock firmware register strobe bus and a buffer memory
// answering each request with a one-cycle done pulse (read data valid on it).
`timescale 1ns/1ps
`default_nettype none
`include "mibuf_consts.svh"
module mibuf_port
  import mibuf_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [5:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  output logic o_busy,
  output logic o_mem_req,
  output logic o_mem_we,
  output logic [`MIBUF_ADR_W-1:0] o_mem_addr,
  output logic [31:0] o_mem_wdata,
  input wire logic i_mem_done,
  input wire logic [31:0] i_mem_rdata
);

  mibuf_regs_t st_r;
  mibuf_regs_t st_nxt;
  logic [7:0] mux_data;

  // ****************************************
  // Readback mux
  // ****************************************
  mibuf_byte_mux u_mux (
    .i_addr(i_reg_addr),
    .i_word({st_r.byte3, st_r.byte2, st_r.byte1, st_r.byte0}),
    .i_adr(st_r.adr),
    .i_dir(st_r.dir),
    .i_busy(st_r.busy),
    .o_data(mux_data)
  );

  // ****************************************
  // Next-state logic
  // ****************************************
  // Writes take priority over reads; writes are ignored while busy, so firmware must wait on busy first
  always_comb begin
    st_nxt = st_r;
    st_nxt.mem_req = 1'b0;
    st_nxt.rdata = i_reg_rd ? mux_data : st_r.rdata;
    case (st_r.state)
      MIBUF_IDLE: begin
        if (i_reg_wr) begin
          case (i_reg_addr)
            `MIBUF_OFS_BYTE0: st_nxt.byte0 = i_reg_wdata;
            `MIBUF_OFS_BYTE1: st_nxt.byte1 = i_reg_wdata;
            `MIBUF_OFS_BYTE2: st_nxt.byte2 = i_reg_wdata;
            `MIBUF_OFS_BYTE3: begin
              st_nxt.byte3 = i_reg_wdata;
              if (!st_r.dir) begin
                // Commit assembled word at current address
                st_nxt.mem_req = 1'b1;
                st_nxt.mem_we = 1'b1;
                st_nxt.mem_adr = st_r.adr;
                st_nxt.mem_wdata = {i_reg_wdata, st_r.byte2, st_r.byte1, st_r.byte0};
                st_nxt.busy = 1'b1;
                st_nxt.state = MIBUF_WR;
              end
            end
            `MIBUF_OFS_ADRL: st_nxt.adr[7:0] = i_reg_wdata;
            `MIBUF_OFS_ADRH: begin
              st_nxt.adr[12:8] = i_reg_wdata[4:0];
              st_nxt.dir = i_reg_wdata[`MIBUF_BIT_DIR];
              if (i_reg_wdata[`MIBUF_BIT_DIR]) begin
                // Read direction: fetch first word of the burst
                st_nxt.mem_req = 1'b1;
                st_nxt.mem_we = 1'b0;
                st_nxt.mem_adr = {i_reg_wdata[4:0], st_r.adr[7:0]};
                st_nxt.busy = 1'b1;
                st_nxt.state = MIBUF_RD;
              end
            end
            default: ;
          endcase
        end else if (i_reg_rd && st_r.dir && i_reg_addr == `MIBUF_OFS_BYTE3) begin
          // Only the last byte read releases the word
          st_nxt.mem_req = 1'b1;
          st_nxt.mem_we = 1'b0;
          st_nxt.mem_adr = st_r.adr;
          st_nxt.busy = 1'b1;
          st_nxt.state = MIBUF_RD;
        end
      end
      MIBUF_WR: begin
        if (i_mem_done) begin
          st_nxt.busy = 1'b0;
          st_nxt.adr = st_r.adr + 13'h0001;
          st_nxt.state = MIBUF_IDLE;
        end
      end
      MIBUF_RD: begin
        if (i_mem_done) begin
          st_nxt.byte0 = i_mem_rdata[7:0];
          st_nxt.byte1 = i_mem_rdata[15:8];
          st_nxt.byte2 = i_mem_rdata[23:16];
          st_nxt.byte3 = i_mem_rdata[31:24];
          st_nxt.busy = 1'b0;
          st_nxt.adr = st_r.adr + 13'h0001;
          st_nxt.state = MIBUF_IDLE;
        end
      end
      default: st_nxt.state = MIBUF_IDLE;
    endcase
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      st_r <= '{state: MIBUF_IDLE, byte0: `MIBUF_RST_BYTE, byte1: `MIBUF_RST_BYTE,
                byte2: `MIBUF_RST_BYTE, byte3: `MIBUF_RST_BYTE, adr: `MIBUF_RST_ADR,
                dir: 1'b0, busy: 1'b0, rdata: 8'h00, mem_req: 1'b0, mem_we: 1'b0,
                mem_adr: `MIBUF_RST_ADR, mem_wdata: 32'h0000_0000};
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from flip-flops
  assign o_reg_rdata = st_r.rdata;
  assign o_busy = st_r.busy;
  assign o_mem_req = st_r.mem_req;
  assign o_mem_we = st_r.mem_we;
  assign o_mem_addr = st_r.mem_adr;
  assign o_mem_wdata = st_r.mem_wdata;

endmodule
`default_nettype wire
